//--- core/dual_jk_flip_flop.sv
// two independent jk storage elements with falling-edge clocks and async set/clear
`timescale 1ns/10ps
module dual_jk_flip_flop (
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   input wire logic [jk_pkg::NUM_ELEMENTS-1:0] edge_clock_input,
   input wire logic [jk_pkg::NUM_ELEMENTS-1:0] j,
   input wire logic [jk_pkg::NUM_ELEMENTS-1:0] k,
   input wire logic [jk_pkg::NUM_ELEMENTS-1:0] async_set_n,
   input wire logic [jk_pkg::NUM_ELEMENTS-1:0] async_clear_n,
   output wire logic [jk_pkg::NUM_ELEMENTS-1:0] q,
   output wire logic [jk_pkg::NUM_ELEMENTS-1:0] q_n
);

   // ---------------------------------------------------------------
   // timing notes
   // ---------------------------------------------------------------
   // every pin crosses five flops, so outputs trail a pin change by five cycles
   // pin pulses shorter than two cycles can vanish in the agreement filter
   // clock pin phases need two cycles each at least, three to be safe
   // j and k must settle three cycles before the clock pin falls
   // ce low freezes filters and storage alike; pending edges resume on return
   // a joint release of set and clear leaves q high, as the stored bit is high

   // ---------------------------------------------------------------
   // one element per generate pass
   // ---------------------------------------------------------------
   // nothing is shared between passes except clock, reset and enable
   for (genvar e = 0; e < jk_pkg::NUM_ELEMENTS; e++) begin : g_element

      pin_if pins ();

      // filtered pin levels and edge tracking
      logic clk_level;
      logic j_level;
      logic k_level;
      logic set_n_level;
      logic clear_n_level;
      logic clk_prev;
      logic j_before;
      logic k_before;
      logic edge_seen;
      logic clock_allowed;
      logic take_edge;

      // storage and its next values
      logic stored;
      logic true_out;
      logic comp_out;
      logic next_stored;
      logic next_true;
      logic next_comp;
      jk_pkg::jk_action_e action;
      jk_pkg::force_e force_mode;

      // ------------------------------------------------------------
      // pin capture
      // ------------------------------------------------------------
      // all five pins are asynchronous to clock, so each is filtered
      assign pins.raw[jk_pkg::PIN_CLK] = edge_clock_input[e];
      assign pins.raw[jk_pkg::PIN_J] = j[e];
      assign pins.raw[jk_pkg::PIN_K] = k[e];
      assign pins.raw[jk_pkg::PIN_SET] = async_set_n[e];
      assign pins.raw[jk_pkg::PIN_CLR] = async_clear_n[e];

      pin_filter u_filter (
         .clock(clock),
         .rst(rst),
         .ce(ce),
         .port(pins.filter)
      );

      // clean levels, named for readability
      assign clk_level = pins.level[jk_pkg::PIN_CLK];
      assign j_level = pins.level[jk_pkg::PIN_J];
      assign k_level = pins.level[jk_pkg::PIN_K];
      assign set_n_level = pins.level[jk_pkg::PIN_SET];
      assign clear_n_level = pins.level[jk_pkg::PIN_CLR];

      // ------------------------------------------------------------
      // edge detection and pre-edge data
      // ------------------------------------------------------------
      // previous clock level; a rise or a steady level yields no edge
      always_ff @(posedge clock) begin
         if (rst) begin
            clk_prev <= jk_pkg::PIN_IDLE[jk_pkg::PIN_CLK];
         end else if (ce) begin
            clk_prev <= clk_level;
         end
      end

      // j/k one cycle old, so a change landing with the edge is not used
      always_ff @(posedge clock) begin
         if (rst) begin
            j_before <= jk_pkg::PIN_IDLE[jk_pkg::PIN_J];
            k_before <= jk_pkg::PIN_IDLE[jk_pkg::PIN_K];
         end else if (ce) begin
            j_before <= j_level;
            k_before <= k_level;
         end
      end

      // j/k are only looked at on an edge; other movement is harmless
      assign edge_seen = jk_pkg::falling(clk_prev, clk_level);
      assign action = jk_pkg::decode_action(j_before, k_before);

      // ------------------------------------------------------------
      // override decode
      // ------------------------------------------------------------
      // set/clear levels are used directly, with no edge involved
      assign force_mode = jk_pkg::decode_force(set_n_level, clear_n_level);

      // ------------------------------------------------------------
      // clock gating by the overrides
      // ------------------------------------------------------------
      // any low override blocks the edge, so a release never replays a stale fall
      assign clock_allowed = (force_mode == jk_pkg::FORCE_NONE);
      assign take_edge = edge_seen & clock_allowed;

      // ------------------------------------------------------------
      // next stored state
      // ------------------------------------------------------------
      // override first, then an accepted falling edge, otherwise hold
      always_comb begin
         next_stored = stored;
         case (force_mode)
            jk_pkg::FORCE_SET: begin
               next_stored = jk_pkg::LEVEL_HIGH;
            end
            jk_pkg::FORCE_CLEAR: begin
               next_stored = jk_pkg::LEVEL_LOW;
            end
            jk_pkg::FORCE_BOTH: begin
               // stored bit left at high so a joint release is defined
               next_stored = jk_pkg::LEVEL_HIGH;
            end
            jk_pkg::FORCE_NONE: begin
               if (take_edge) begin
                  next_stored = jk_pkg::jk_next(action, stored);
               end
            end
            default: begin
               next_stored = stored;
            end
         endcase
      end

      // ------------------------------------------------------------
      // output selection
      // ------------------------------------------------------------
      // both outputs high is legal under a double override, so they are not tied
      always_comb begin
         next_true = next_stored;
         next_comp = ~next_stored;
         case (force_mode)
            jk_pkg::FORCE_SET: begin
               next_true = jk_pkg::LEVEL_HIGH;
               next_comp = jk_pkg::LEVEL_LOW;
            end
            jk_pkg::FORCE_CLEAR: begin
               next_true = jk_pkg::LEVEL_LOW;
               next_comp = jk_pkg::LEVEL_HIGH;
            end
            jk_pkg::FORCE_BOTH: begin
               next_true = jk_pkg::LEVEL_HIGH;
               next_comp = jk_pkg::LEVEL_HIGH;
            end
            default: begin
               next_true = next_stored;
               next_comp = ~next_stored;
            end
         endcase
      end

      // ------------------------------------------------------------
      // state register
      // ------------------------------------------------------------
      // stored bit kept apart from outputs, since both outputs may be high
      always_ff @(posedge clock) begin
         if (rst) begin
            stored <= jk_pkg::STATE_RESET;
         end else if (ce) begin
            stored <= next_stored;
         end
      end

      // ------------------------------------------------------------
      // output registers
      // ------------------------------------------------------------
      // true output registered so the pin never sees decode glitches
      always_ff @(posedge clock) begin
         if (rst) begin
            true_out <= jk_pkg::STATE_RESET;
         end else if (ce) begin
            true_out <= next_true;
         end
      end

      // complement has its own flop, as it is not always the inverse of q
      always_ff @(posedge clock) begin
         if (rst) begin
            comp_out <= ~jk_pkg::STATE_RESET;
         end else if (ce) begin
            comp_out <= next_comp;
         end
      end

      assign q[e] = true_out;
      assign q_n[e] = comp_out;

   end : g_element

endmodule : dual_jk_flip_flop

//--- pkg/jk_pkg.sv
// constants, types and helper functions shared by the dual jk storage design
package jk_pkg;

   // ---------------------------------------------------------------
   // structure
   // ---------------------------------------------------------------
   localparam int NUM_ELEMENTS = 2;
   localparam int NUM_PINS = 5;

   // bit positions of one element's pins inside its pin vector
   localparam int PIN_CLK = 0;
   localparam int PIN_J = 1;
   localparam int PIN_K = 2;
   localparam int PIN_SET = 3;
   localparam int PIN_CLR = 4;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   // pins assumed idle at reset: set/clear released, clock/j/k low
   localparam logic [NUM_PINS-1:0] PIN_IDLE = 5'h18;
   localparam logic STATE_RESET = 1'h0;
   localparam logic LEVEL_HIGH = 1'h1;
   localparam logic LEVEL_LOW = 1'h0;

   // ---------------------------------------------------------------
   // encodings
   // ---------------------------------------------------------------
   // synchronous action, coded as {j, k}
   typedef enum logic [1:0] {
      JK_HOLD = 2'h0,
      JK_RESET = 2'h1,
      JK_SET = 2'h2,
      JK_TOGGLE = 2'h3
   } jk_action_e;

   // asynchronous override, coded as {set active, clear active}
   typedef enum logic [1:0] {
      FORCE_NONE = 2'h0,
      FORCE_CLEAR = 2'h1,
      FORCE_SET = 2'h2,
      FORCE_BOTH = 2'h3
   } force_e;

   // ---------------------------------------------------------------
   // helper functions
   // ---------------------------------------------------------------
   function automatic jk_action_e decode_action(input logic j, input logic k);
      return jk_action_e'({j, k});
   endfunction : decode_action

   function automatic force_e decode_force(input logic set_n, input logic clear_n);
      return force_e'({~set_n, ~clear_n});
   endfunction : decode_force

   function automatic logic falling(input logic prev, input logic now);
      return (prev == LEVEL_HIGH) && (now == LEVEL_LOW);
   endfunction : falling

   function automatic logic jk_next(input jk_action_e action, input logic prior);
      logic result;
      result = prior;
      case (action)
         JK_HOLD: result = prior;
         JK_RESET: result = LEVEL_LOW;
         JK_SET: result = LEVEL_HIGH;
         JK_TOGGLE: result = ~prior;
         default: result = prior;
      endcase
      return result;
   endfunction : jk_next

endpackage : jk_pkg

//--- pkg/pin_if.sv
// bundle of one element's raw pins and their filtered levels
`timescale 1ns/10ps
interface pin_if;
   logic [jk_pkg::NUM_PINS-1:0] raw;
   logic [jk_pkg::NUM_PINS-1:0] level;

   // the element side drives raw pins and reads clean levels
   modport element (output raw, input level);
   // the filter side does the opposite
   modport filter (input raw, output level);
endinterface : pin_if

//--- core/pin_filter.sv
// three-stage synchroniser and agreement filter for one element's pins
`timescale 1ns/10ps
module pin_filter (
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   pin_if.filter port
);

   logic [jk_pkg::NUM_PINS-1:0] stage1;
   logic [jk_pkg::NUM_PINS-1:0] stage2;
   logic [jk_pkg::NUM_PINS-1:0] stage3;
   logic [jk_pkg::NUM_PINS-1:0] agree;
   logic [jk_pkg::NUM_PINS-1:0] level;

   // ---------------------------------------------------------------
   // synchroniser chain
   // ---------------------------------------------------------------
   // stage1 feeds stage2 only; it may be metastable
   always_ff @(posedge clock) begin
      if (rst) begin
         stage1 <= jk_pkg::PIN_IDLE;
         stage2 <= jk_pkg::PIN_IDLE;
         stage3 <= jk_pkg::PIN_IDLE;
      end else if (ce) begin
         stage1 <= port.raw;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // ---------------------------------------------------------------
   // agreement filter
   // ---------------------------------------------------------------
   // a bit moves only once stages two and three match, so a one-cycle glitch is dropped
   assign agree = ~(stage2 ^ stage3);

   always_ff @(posedge clock) begin
      if (rst) begin
         level <= jk_pkg::PIN_IDLE;
      end else if (ce) begin
         level <= (agree & stage3) | (~agree & level);
      end
   end

   assign port.level = level;

endmodule : pin_filter

//--- testbench/dual_jk_monitor.sv
// concurrent checks on the ports of the dual jk storage block
`timescale 1ns/10ps
module dual_jk_monitor (
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   input wire logic [1:0] edge_clock_input,
   input wire logic [1:0] j,
   input wire logic [1:0] k,
   input wire logic [1:0] async_set_n,
   input wire logic [1:0] async_clear_n,
   input wire logic [1:0] q,
   input wire logic [1:0] q_n
);
   // pins reach the outputs five cycles late, so every window spans six samples or more
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // ce sits in every window: a freeze leaves pin changes waiting in the pipeline
   wire logic r0 = ce & async_set_n[0] & async_clear_n[0];
   wire logic c0 = edge_clock_input[0];
   // clean fall of element 0, jk held three samples before and two after
   sequence fall0(logic jv, logic kv);
      (r0 && j[0] == jv && k[0] == kv && c0)[*3] ##1
      (r0 && j[0] == jv && k[0] == kv && !c0)[*2] ##1 (r0 && !c0)[*4];
   endsequence
   a_set_high: assert property (
      (ce && !async_set_n[0] && async_clear_n[0])[*6] |-> q[0] && !q_n[0])
      else $error("set did not force q high");
   a_clear_low: assert property (
      (ce && async_set_n[0] && !async_clear_n[0])[*6] |-> !q[0] && q_n[0])
      else $error("clear did not force q low");
   a_both_high: assert property (
      (ce && !async_set_n[0] && !async_clear_n[0])[*6] |-> q[0] && q_n[0])
      else $error("both forces did not lift both outputs");
   a_outputs_opposite: assert property (
      r0[*6] |-> q[0] != q_n[0])
      else $error("complement output not inverse");
   a_toggle_fall: assert property (
      fall0(1'h1, 1'h1) |-> q[0] != $past(q[0]))
      else $error("toggle missed");
   a_store_low: assert property (
      fall0(1'h0, 1'h1) |-> !q[0] && q_n[0])
      else $error("reset action missed");
   a_store_high: assert property (
      fall0(1'h1, 1'h0) |-> q[0] && !q_n[0])
      else $error("set action missed");
   a_hold_fall: assert property (
      fall0(1'h0, 1'h0) |-> $stable(q[0]))
      else $error("hold action changed q");
   a_steady_clock: assert property (
      (r0 && $stable(c0))[*7] |-> $stable(q[0]) && $stable(q_n[0]))
      else $error("q moved without a falling edge");
   a_elements_apart: assert property (
      (ce && $stable({edge_clock_input[1], j[1], k[1], async_set_n[1], async_clear_n[1]}))[*7]
      |-> $stable(q[1]) && $stable(q_n[1]))
      else $error("element 1 moved with its pins still");
endmodule : dual_jk_monitor
bind dual_jk_flip_flop dual_jk_monitor u_mon (.clock(clock), .rst(rst), .ce(ce),
   .edge_clock_input(edge_clock_input), .j(j), .k(k), .async_set_n(async_set_n),
   .async_clear_n(async_clear_n), .q(q), .q_n(q_n));

//--- testbench/pin_driver.sv
// partner model: surrounding logic driving the clock and jk pins
`timescale 1ns/10ps
module pin_driver (
   input wire logic clock,
   output logic [1:0] edge_clock,
   output logic [1:0] j,
   output logic [1:0] k
);
   initial begin
      edge_clock = 2'h0;
      j = 2'h0;
      k = 2'h0;
   end
   // raise clocks and load jk together; a rise alone must not move q
   task automatic arm(input logic [1:0] jv, input logic [1:0] kv);
      @(posedge clock);
      edge_clock <= 2'h3;
      j <= jv;
      k <= kv;
      repeat (6) @(posedge clock);
   endtask : arm
   // drop chosen clocks, keep jk two cycles, then move jk to stale values on purpose
   task automatic fall(input logic [1:0] sel, input logic [1:0] jn, input logic [1:0] kn);
      @(posedge clock);
      edge_clock <= edge_clock & ~sel;
      repeat (2) @(posedge clock);
      j <= jn;
      k <= kn;
      repeat (5) @(posedge clock);
   endtask : fall
endmodule : pin_driver

//--- testbench/test_dual_jk_flip_flop.sv
// self-checking bench for the dual jk storage block
`timescale 1ns/10ps
module test_dual_jk_flip_flop;
   logic clock = 1'h0;
   logic rst = 1'h1;
   logic ce = 1'h1;
   logic [1:0] set_n = 2'h3;
   logic [1:0] clear_n = 2'h3;
   logic [1:0] st = 2'h0;
   logic [31:0] seed = 32'h151FB5E7;
   wire logic [1:0] clk_pin, jp, kp, q, q_n;
   int miscompares = 0;
   int checks_done = 0;
   always #25 clock = ~clock;
   pin_driver u_drv (.clock(clock), .edge_clock(clk_pin), .j(jp), .k(kp));
   dual_jk_flip_flop DUT (.clock(clock), .rst(rst), .ce(ce), .edge_clock_input(clk_pin),
      .j(jp), .k(kp), .async_set_n(set_n), .async_clear_n(clear_n), .q(q), .q_n(q_n));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // both forces low lift q_n as well as q
   function automatic logic [3:0] outs(input logic [1:0] s, sn, cn);
      return {s, ~s | (~sn & ~cn)};
   endfunction : outs
   task automatic chk(input logic [3:0] want);
      checks_done++;
      if ({q, q_n} !== want) begin
         miscompares++;
         $display("CHECK FAILED at %0t: q,q_n %h expected %h", $time, {q, q_n}, want);
      end
   endtask : chk
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : summarize
   // forces and jk with clocks high, then a fall on sel; forced elements ignore it
   task automatic op(input logic [1:0] sn, cn, jv, kv, sel, jn, kn);
      logic [1:0] m;
      @(posedge clock);
      set_n <= sn;
      clear_n <= cn;
      u_drv.arm(jv, kv);
      st = (st & sn & cn) | ~sn;
      @(negedge clock);
      chk(outs(st, sn, cn));
      u_drv.fall(sel, jn, kn);
      m = sel & sn & cn;
      st = (st & ~m) | (m & ((jv & ~st) | (~kv & st)));
      @(negedge clock);
      chk(outs(st, sn, cn));
   endtask : op
   // forces given while frozen must wait for the enable to return
   task automatic freeze(input logic [1:0] sn, cn);
      @(posedge clock);
      ce <= 1'h0;
      set_n <= sn;
      clear_n <= cn;
      repeat (10) @(posedge clock);
      @(negedge clock);
      chk(outs(st, 2'h3, 2'h3));
      @(posedge clock);
      ce <= 1'h1;
      st = (st & sn & cn) | ~sn;
      repeat (7) @(posedge clock);
      @(negedge clock);
      chk(outs(st, sn, cn));
   endtask : freeze
   initial begin
      repeat (16) @(posedge clock);
      rst <= 1'h0;
      @(negedge clock);
      chk(4'h3);
      // corner cases: each jk action, each force, one element alone
      op(2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h0, 2'h0);
      op(2'h3, 2'h3, 2'h1, 2'h2, 2'h3, 2'h2, 2'h1);
      op(2'h3, 2'h3, 2'h2, 2'h1, 2'h3, 2'h1, 2'h2);
      op(2'h3, 2'h3, 2'h0, 2'h0, 2'h3, 2'h3, 2'h3);
      op(2'h3, 2'h3, 2'h3, 2'h3, 2'h1, 2'h2, 2'h2);
      freeze(2'h2, 2'h1);
      op(2'h2, 2'h3, 2'h3, 2'h3, 2'h3, 2'h0, 2'h0);
      op(2'h3, 2'h2, 2'h3, 2'h3, 2'h3, 2'h0, 2'h0);
      op(2'h0, 2'h0, 2'h3, 2'h3, 2'h3, 2'h0, 2'h0);
      for (int n = 0; n < 40; n++) begin
         seed = lfsr(seed);
         op(~(seed[1:0] & seed[3:2]), ~(seed[5:4] & seed[7:6]), seed[9:8], seed[11:10],
            seed[13:12], seed[15:14], seed[17:16]);
      end
      summarize();
   end
   // about 800 cycles of work; cut off far beyond that
   initial begin
      #(50 * 5000);
      miscompares++;
      summarize();
   end
endmodule : test_dual_jk_flip_flop
